// ### verilog/systk_top.sv
// System tick down counter, controls and status as plain ports.
// Assumes synchronous inputs on CLOCK_IN; read and write strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module systk_top #(
  parameter int WIDTH = systk_pkg::COUNT_WIDTH
) (
  input  wire logic             CLOCK_IN,
  input  wire logic             SRST_IN,
  input  wire logic             ENABLE_IN,
  input  wire logic             COUNT_TICK_IN,
  input  wire logic [WIDTH-1:0] RELOAD_VALUE_IN,
  input  wire logic             CURRENT_WRITE_IN,
  input  wire logic             STATUS_READ_IN,
  output logic      [WIDTH-1:0] CURRENT_COUNT_VALUE_OUT,
  output logic                  COUNT_REACHED_FLAG_OUT
);
  // ==========================================================================
  // Counter
  logic [WIDTH-1:0] current_count_value;
  logic [WIDTH-1:0] next_count;
  logic             hits_zero;
  logic             step;
  logic             count_reached_flag;

  assign step = ENABLE_IN && COUNT_TICK_IN;

  // ==========================================================================
  // Events
  logic set_event;
  logic load_event;
  logic clear_event;

  // A write beats a step in the same cycle, so it neither counts nor sets the flag
  // Reads are plain strobes; a set in the same cycle still wins over them
  assign set_event   = step && hits_zero && (current_count_value != '0)
                       && !CURRENT_WRITE_IN;
  assign load_event  = step && (current_count_value == '0) && !CURRENT_WRITE_IN;
  assign clear_event = STATUS_READ_IN;

  systk_dec #(
    .WIDTH (WIDTH)
  ) u_dec (
    .count_in       (current_count_value),
    .reload_in      (RELOAD_VALUE_IN),
    .next_count_out (next_count),
    .hits_zero_out  (hits_zero)
  );

  // Reset value is a convenience only; software must not rely on it
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      current_count_value <= WIDTH'(systk_pkg::RESET_COUNT);
    end
    else if (CURRENT_WRITE_IN)
    begin
      current_count_value <= '0;
    end
    else if (step)
    begin
      current_count_value <= next_count;
    end
  end

  // ==========================================================================
  // Flag: a set in the same cycle as a clearing read wins
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      count_reached_flag <= 1'b0;
    end
    else if (set_event)
    begin
      count_reached_flag <= 1'b1;
    end
    else if (clear_event)
    begin
      count_reached_flag <= 1'b0;
    end
  end

  assign CURRENT_COUNT_VALUE_OUT = current_count_value;
  assign COUNT_REACHED_FLAG_OUT  = count_reached_flag;

  // ==========================================================================
  // Check helpers: remember the last value loaded, as the count never climbs above it
  logic [WIDTH-1:0] loaded_value;
  logic             loaded_known;

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      loaded_known <= 1'b0;
      loaded_value <= '0;
    end
    else if (load_event)
    begin
      loaded_known <= 1'b1;
      loaded_value <= RELOAD_VALUE_IN;
    end
  end

  // ==========================================================================
  // Checks
  property p_dec;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (step && !CURRENT_WRITE_IN && current_count_value != '0)
      |=> current_count_value == $past(current_count_value) - 1'b1;
  endproperty
  a_dec: assert property (p_dec) else $error("count did not decrement");

  property p_reload;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (step && !CURRENT_WRITE_IN && current_count_value == '0)
      |=> current_count_value == $past(RELOAD_VALUE_IN);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero");

  property p_set;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (step && !CURRENT_WRITE_IN && current_count_value == systk_pkg::COUNT_ONE)
      |=> count_reached_flag;
  endproperty
  a_set: assert property (p_set) else $error("flag not set at zero");

  property p_clr;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (STATUS_READ_IN && !(step && current_count_value == systk_pkg::COUNT_ONE))
      |=> !count_reached_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("read did not clear flag");

  property p_wr;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      CURRENT_WRITE_IN |=> current_count_value == systk_pkg::COUNT_ZERO;
  endproperty
  a_wr: assert property (p_wr) else $error("write did not clear count");

  property p_zero_reload;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (current_count_value == '0 && RELOAD_VALUE_IN == '0 && !CURRENT_WRITE_IN)
      |=> current_count_value == '0;
  endproperty
  a_zero_reload: assert property (p_zero_reload) else $error("zero reload moved");

  property p_hold;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (!ENABLE_IN && !CURRENT_WRITE_IN)
      |=> $stable(current_count_value);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");

  property p_noset;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (!ENABLE_IN && !count_reached_flag) |=> !count_reached_flag;
  endproperty
  a_noset: assert property (p_noset) else $error("flag set while disabled");

  property p_stand;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (count_reached_flag && !STATUS_READ_IN) |=> count_reached_flag;
  endproperty
  a_stand: assert property (p_stand) else $error("flag dropped without a read");

  property p_set_cause;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (!count_reached_flag && !(step && current_count_value == systk_pkg::COUNT_ONE))
      |=> !count_reached_flag;
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("flag set away from zero");

  property p_wr_no_set;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (CURRENT_WRITE_IN && !count_reached_flag) |=> !count_reached_flag;
  endproperty
  a_wr_no_set: assert property (p_wr_no_set) else $error("write set the flag");

  property p_tick_gate;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (!COUNT_TICK_IN && !CURRENT_WRITE_IN) |=> $stable(current_count_value);
  endproperty
  a_tick_gate: assert property (p_tick_gate) else $error("count moved without a tick");

  property p_idle;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (!step && !CURRENT_WRITE_IN) |=> $stable(current_count_value);
  endproperty
  a_idle: assert property (p_idle) else $error("count moved without a step");

  // Runs through reset, so it has no disable clause
  property p_reset;
    @(posedge CLOCK_IN)
      SRST_IN |=> (current_count_value == systk_pkg::RESET_COUNT) && !count_reached_flag;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left state behind");

  // Quiet until the first reload has been seen
  property p_bound;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      loaded_known |-> (current_count_value <= loaded_value);
  endproperty
  a_bound: assert property (p_bound) else $error("count above last load");

  property p_zero_no_set;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (step && !CURRENT_WRITE_IN && current_count_value == '0 && RELOAD_VALUE_IN == '0)
      |=> !$rose(count_reached_flag);
  endproperty
  a_zero_no_set: assert property (p_zero_no_set) else $error("flag set staying at zero");

  property p_load_flag;
    @(posedge CLOCK_IN) disable iff (SRST_IN)
      (step && !CURRENT_WRITE_IN && current_count_value == '0 && !STATUS_READ_IN)
      |=> $stable(count_reached_flag);
  endproperty
  a_load_flag: assert property (p_load_flag) else $error("reload touched the flag");
endmodule
`default_nettype wire

// ### verilog/systk_pkg.sv
// Constants for the system tick down counter.
// Assumes a single core clock domain and plain control ports.
//
// Contract
// - The tick timer is a 24-bit counter that decrements by one per count and reloads at zero.
// - While enabled it counts down to zero, loads the reload value on the next count, then decrements.
// - The count-reached flag is set whenever the counter value transitions to zero; the code sets it only when a step counts from one, not on a write.
// - A software read of the flag's register clears the flag as a side effect.
// - After reset the current count value is undefined and need not be initialised.
// - A write of any value to the current value clears the counter to zero.
// - With a reload value of zero the counter stays at zero after reloading.
package systk_pkg;
  // ==========================================================================
  // Widths and values
  localparam int          COUNT_WIDTH = 24;
  localparam logic [23:0] COUNT_ZERO  = 24'h000000;
  localparam logic [23:0] COUNT_ONE   = 24'h000001;
  localparam logic [23:0] RESET_COUNT = 24'h000000;
endpackage

// ### verilog/systk_dec.sv
// Next-value logic for the tick counter.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module systk_dec #(
  parameter int WIDTH = 24
) (
  input  wire logic [WIDTH-1:0] count_in,
  input  wire logic [WIDTH-1:0] reload_in,
  output logic      [WIDTH-1:0] next_count_out,
  output logic                  hits_zero_out
);
  // ==========================================================================
  // Decrement or reload
  always_comb
  begin
    if (count_in == '0)
    begin
      next_count_out = reload_in;
    end
    else
    begin
      next_count_out = count_in - {{(WIDTH-1){1'b0}}, 1'b1};
    end
    hits_zero_out = (next_count_out == '0);
  end
endmodule
`default_nettype wire

// ### testbench/systk_tb.sv
// Self-checking bench for the system tick down counter.
// Assumes the design files come first; ports change 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================================================
  // Ports and counters
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic        en   = 1'b0;
  logic        tick = 1'b0;
  logic [23:0] rld  = 24'h000000;
  logic        wr   = 1'b0;
  logic        rd   = 1'b0;
  logic [23:0] cnt;
  logic        flg;
  int          n_errors     = 0;
  int          total_checks = 0;
  always #2.5 clk = ~clk;
  systk_top dut (.CLOCK_IN(clk), .SRST_IN(srst), .ENABLE_IN(en), .COUNT_TICK_IN(tick),
    .RELOAD_VALUE_IN(rld), .CURRENT_WRITE_IN(wr), .STATUS_READ_IN(rd),
    .CURRENT_COUNT_VALUE_OUT(cnt), .COUNT_REACHED_FLAG_OUT(flg));
  // ==========================================================================
  // Access tasks
  task automatic cyc(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
    end
  endtask
  // Strobes last exactly one edge, as the design expects single pulses
  task automatic wr_cur();
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic rd_stat();
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
  endtask
  task automatic look(input logic [23:0] c, input logic f);
    total_checks += 2;
    if (cnt !== c)
    begin
      n_errors++;
      $display("BAD count expected %h seen %h", c, cnt);
    end
    if (flg !== f)
    begin
      n_errors++;
      $display("BAD flag expected %b seen %b", f, flg);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial
  begin
    cyc(16);
    srst = 1'b0;
    rld = 24'h000002;
    wr_cur();
    look(24'h000000, 1'b0);
    en = 1'b1;
    tick = 1'b1;
    cyc(1);
    look(24'h000002, 1'b0);
    cyc(1);
    look(24'h000001, 1'b0);
    cyc(1);
    look(24'h000000, 1'b1);
    cyc(1);
    look(24'h000002, 1'b1);
    rd_stat();
    look(24'h000001, 1'b0);
    $display("test walk done");
    en = 1'b0;
    cyc(3);
    look(24'h000001, 1'b0);
    en = 1'b1;
    cyc(1);
    en = 1'b0;
    cyc(3);
    look(24'h000000, 1'b1);
    en = 1'b1;
    tick = 1'b0;
    cyc(2);
    look(24'h000000, 1'b1);
    $display("test hold done");
    rld = 24'h000000;
    tick = 1'b1;
    rd_stat();
    cyc(4);
    look(24'h000000, 1'b0);
    rld = 24'hFFFFFF;
    cyc(1);
    look(24'hFFFFFF, 1'b0);
    cyc(1);
    look(24'hFFFFFE, 1'b0);
    wr_cur();
    look(24'h000000, 1'b0);
    cyc(1);
    look(24'hFFFFFF, 1'b0);
    $display("test wrap done");
    rld = 24'h000002;
    wr_cur();
    look(24'h000000, 1'b0);
    cyc(2);
    look(24'h000001, 1'b0);
    rd_stat();
    look(24'h000000, 1'b1);
    cyc(1);
    rd_stat();
    look(24'h000001, 1'b0);
    wr_cur();
    look(24'h000000, 1'b0);
    cyc(1);
    look(24'h000002, 1'b0);
    $display("test collide done");
    cyc(2);
    look(24'h000000, 1'b1);
    en = 1'b0;
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    wr_cur();
    look(24'h000000, 1'b0);
    en = 1'b1;
    cyc(1);
    look(24'h000002, 1'b0);
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
